// ==== pwsc_power_switch_control.sv ====
// Purpose: power on/off sequencing from a slider or push-button switch
// Assumes: all pins synchronous to clk_in except the switch, which is synchronised
// Notes:   strap is caught once after reset release; later changes are ignored
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module pwsc_power_switch_control #(
	parameter int unsigned DEBOUNCE_CYCLES = pwsc_pkg::DEBOUNCE_CYC,
	parameter int unsigned POWERUP_CYCLES  = pwsc_pkg::POWERUP_CYC
) (
	// clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	// pins from switch, strap and host
	input  wire logic                        power_switch_n_in,
	input  wire logic                        switch_type_select_in,
	input  wire logic                        sleep_request_in,
	input  wire logic                        boost_request_in,
	// power controls
	output logic                             regulator_enable_out,
	output logic                             boost_enable_pin_out,
	output logic                             supervisor_active_out,
	output logic                             charger_active_out,
	// avalon-mm slave
	input  wire logic [pwsc_pkg::ADDR_W-1:0] avs_address_in,
	input  wire logic                        avs_read_in,
	input  wire logic                        avs_write_in,
	input  wire logic [31:0]                 avs_writedata_in,
	output logic      [31:0]                 avs_readdata_out,
	output logic                             avs_waitrequest_out
);

	localparam int unsigned PW = $clog2(POWERUP_CYCLES + 1);

	if (POWERUP_CYCLES < 1) begin : g_powerup_check
		$error("pwsc_power_switch_control: POWERUP_CYCLES must be at least 1");
	end
	if (DEBOUNCE_CYCLES < 1) begin : g_debounce_check
		$error("pwsc_power_switch_control: DEBOUNCE_CYCLES must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////
	// switch filtering and sleep request watch

	logic sw_level;
	logic sw_stable;
	logic sw_press;
	logic sleep_armed;
	logic sleep_fall;

	pwsc_debounce #(
		.CYCLES (DEBOUNCE_CYCLES)
	) u_debounce (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.raw_in     (power_switch_n_in),
		.level_out  (sw_level),
		.stable_out (sw_stable),
		.press_out  (sw_press)
	);

	pwsc_pkg::pwsc_state_t state_reg;
	pwsc_pkg::pwsc_state_t state_next;

	pwsc_sleep_watch u_sleep_watch (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.arm_enable_in (state_reg == pwsc_pkg::ST_NORMAL),
		.clear_in      (state_reg == pwsc_pkg::ST_SLEEP),
		.request_in    (sleep_request_in),
		.armed_out     (sleep_armed),
		.fall_out      (sleep_fall)
	);

	////////////////////////////////////////////////////////////////////////////
	// strap capture, clocked after reset release rather than under reset

	logic strap_valid_reg;
	logic strap_valid_next;
	logic push_mode_reg;
	logic push_mode_next;

	always_comb begin
		strap_valid_next = 1'b1;
		push_mode_next   = push_mode_reg;
		if (!strap_valid_reg)
			push_mode_next = switch_type_select_in;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			strap_valid_reg <= 1'b0;
			push_mode_reg   <= 1'b0;
		end else begin
			strap_valid_reg <= strap_valid_next;
			push_mode_reg   <= push_mode_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register bus: one wait cycle, then the answer

	logic        wait_reg;
	logic        wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        boost_permit_reg;
	logic        boost_permit_next;
	logic        soft_off_reg;
	logic        soft_off_next;
	logic        bus_take;

	pwsc_pkg::pwsc_status_t status;

	always_comb begin
		status                 = '0;
		status.state           = state_reg;
		status.push_button     = push_mode_reg;
		status.switch_level    = sw_level;
		status.debounced_level = sw_stable;
		status.sleep_armed     = sleep_armed;
		status.regulator_en    = regulator_enable_out;
		status.boost_en        = boost_enable_pin_out;
	end

	function automatic logic [31:0] read_word(
		input logic [pwsc_pkg::ADDR_W-1:0] addr,
		input logic                        permit,
		input pwsc_pkg::pwsc_status_t      st
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (addr)
			pwsc_pkg::REG_CTRL_OFS:   w[pwsc_pkg::CTRL_BOOST_BIT] = permit;
			pwsc_pkg::REG_STATUS_OFS: w[$bits(st)-1:0] = st;
			default:                  w = 32'h0000_0000;
		endcase
		return w;
	endfunction : read_word

	always_comb begin
		bus_take          = avs_write_in && !wait_reg;
		wait_next         = !((avs_read_in || avs_write_in) && wait_reg);
		rdata_next        = rdata_reg;
		boost_permit_next = boost_permit_reg;
		soft_off_next     = 1'b0;
		if (avs_read_in && wait_reg)
			rdata_next = read_word(avs_address_in, boost_permit_reg, status);
		// a write lands only at the edge where waitrequest is seen low
		if (bus_take && avs_address_in == pwsc_pkg::REG_CTRL_OFS) begin
			boost_permit_next = avs_writedata_in[pwsc_pkg::CTRL_BOOST_BIT];
			soft_off_next     = avs_writedata_in[pwsc_pkg::CTRL_OFF_BIT];
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wait_reg         <= 1'b1;
			rdata_reg        <= 32'h0000_0000;
			boost_permit_reg <= pwsc_pkg::CTRL_RST[pwsc_pkg::CTRL_BOOST_BIT];
			soft_off_reg     <= 1'b0;
		end else begin
			wait_reg         <= wait_next;
			rdata_reg        <= rdata_next;
			boost_permit_reg <= boost_permit_next;
			soft_off_reg     <= soft_off_next;
		end
	end

	assign avs_waitrequest_out = wait_reg;
	assign avs_readdata_out    = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// power state machine

	logic [PW-1:0] pu_cnt_reg;
	logic [PW-1:0] pu_cnt_next;
	logic          switch_on;
	logic          switch_off;
	logic          off_event;

	always_comb begin
		// slider follows the level; push-button toggles on a qualified press
		switch_on  = push_mode_reg ? sw_press : !sw_level;
		switch_off = push_mode_reg ? sw_press : sw_level;
		off_event  = switch_off || sleep_fall || soft_off_reg;
		state_next  = state_reg;
		pu_cnt_next = '0;
		case (state_reg)
			pwsc_pkg::ST_SLEEP: begin
				if (strap_valid_reg && switch_on)
					state_next = pwsc_pkg::ST_POWER_UP;
			end
			pwsc_pkg::ST_POWER_UP: begin
				pu_cnt_next = pu_cnt_reg + PW'(1);
				if (off_event)
					state_next = pwsc_pkg::ST_SLEEP;
				else if (pu_cnt_reg == PW'(POWERUP_CYCLES - 1))
					state_next = pwsc_pkg::ST_NORMAL;
			end
			pwsc_pkg::ST_NORMAL: begin
				if (off_event)
					state_next = pwsc_pkg::ST_SLEEP;
			end
			default: state_next = pwsc_pkg::ST_SLEEP;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg  <= pwsc_pkg::ST_SLEEP;
			pu_cnt_reg <= '0;
		end else begin
			state_reg  <= state_next;
			pu_cnt_reg <= pu_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output drive: regulator and boost registered from the next state so they track it exactly; supervisor and charger are held on

	logic reg_en_reg;
	logic reg_en_next;
	logic boost_en_reg;
	logic boost_en_next;
	logic sup_reg;
	logic chg_reg;

	always_comb begin
		reg_en_next   = state_next != pwsc_pkg::ST_SLEEP;
		boost_en_next = state_next == pwsc_pkg::ST_NORMAL && boost_request_in
			&& boost_permit_reg;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reg_en_reg   <= 1'b0;
			boost_en_reg <= 1'b0;
			sup_reg      <= 1'b1;
			chg_reg      <= 1'b1;
		end else begin
			reg_en_reg   <= reg_en_next;
			boost_en_reg <= boost_en_next;
			sup_reg      <= 1'b1;
			chg_reg      <= 1'b1;
		end
	end

	assign regulator_enable_out  = reg_en_reg;
	assign boost_enable_pin_out  = boost_en_reg;
	assign supervisor_active_out = sup_reg;
	assign charger_active_out    = chg_reg;

endmodule : pwsc_power_switch_control

// ==== pwsc_pkg.sv ====
// Purpose: shared constants and types of the power switch control block
// Assumes: 125 MHz system clock, synchronous active-high reset
// Notes:   register map reached over Avalon-MM with waitrequest
package pwsc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned     CLK_HZ          = 125_000_000;
	localparam int unsigned     DEBOUNCE_MS     = 32;
	// least time, rounded up; product exceeds the signed 32-bit range so work in 64
	localparam longint unsigned DEBOUNCE_CYC_L  =
		(longint'(DEBOUNCE_MS) * longint'(CLK_HZ) + 64'd999) / 64'd1000;
	localparam int unsigned     DEBOUNCE_CYC    = int'(DEBOUNCE_CYC_L);
	localparam int unsigned     POWERUP_NS      = 1000;
	localparam longint unsigned POWERUP_CYC_L   =
		(longint'(POWERUP_NS) * longint'(CLK_HZ) + 64'd999_999_999) / 64'd1_000_000_000;
	localparam int unsigned     POWERUP_CYC     = int'(POWERUP_CYC_L);

	////////////////////////////////////////////////////////////////////////////
	// register map
	localparam int unsigned     ADDR_W          = 4;
	localparam logic [3:0]      REG_CTRL_OFS    = 4'h0;
	localparam logic [3:0]      REG_STATUS_OFS  = 4'h4;
	localparam int unsigned     CTRL_OFF_BIT    = 0;
	localparam int unsigned     CTRL_BOOST_BIT  = 1;
	localparam logic [31:0]     CTRL_RST        = 32'h0000_0002;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		ST_SLEEP,
		ST_POWER_UP,
		ST_NORMAL
	} pwsc_state_t;

	typedef struct packed {
		logic [1:0] state;
		logic       push_button;
		logic       switch_level;
		logic       debounced_level;
		logic       sleep_armed;
		logic       regulator_en;
		logic       boost_en;
	} pwsc_status_t;

endpackage : pwsc_pkg

// ==== pwsc_debounce.sv ====
// Purpose: synchroniser and debounce filter for the power switch input
// Assumes: input is a raw pin level, one clock
// Notes:   press pulse marks a debounced high-to-low change
`timescale 1ns/1ps
module pwsc_debounce #(
	parameter int unsigned CYCLES = pwsc_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// switch pin
	input  wire logic raw_in,
	// filtered views
	output logic      level_out,
	output logic      stable_out,
	output logic      press_out
);

	localparam int unsigned CW = $clog2(CYCLES + 1);

	// refused at elaboration: a zero count would never qualify a press
	if (CYCLES < 1) begin : g_cycles_check
		$error("pwsc_debounce: CYCLES must be at least 1");
	end

	logic          meta_reg;
	logic          sync_reg;
	logic          stable_reg;
	logic          stable_next;
	logic          press_reg;
	logic          press_next;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		stable_next = stable_reg;
		press_next  = 1'b0;
		cnt_next    = cnt_reg;
		if (sync_reg == stable_reg) begin
			cnt_next = '0;
		end else if (cnt_reg == CW'(CYCLES - 1)) begin
			stable_next = sync_reg;
			press_next  = ~sync_reg;
			cnt_next    = '0;
		end else begin
			cnt_next = cnt_reg + CW'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_reg   <= 1'b1;
			sync_reg   <= 1'b1;
			stable_reg <= 1'b1;
			press_reg  <= 1'b0;
			cnt_reg    <= '0;
		end else begin
			meta_reg   <= raw_in;
			sync_reg   <= meta_reg;
			stable_reg <= stable_next;
			press_reg  <= press_next;
			cnt_reg    <= cnt_next;
		end
	end

	assign level_out  = sync_reg;
	assign stable_out = stable_reg;
	assign press_out  = press_reg;

endmodule : pwsc_debounce

// ==== pwsc_sleep_watch.sv ====
// Purpose: arms on a high sleep request and flags its falling edge
// Assumes: sleep request is synchronous to the clock
// Notes:   a fall before arming is ignored on purpose
`timescale 1ns/1ps
module pwsc_sleep_watch (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// control
	input  wire logic arm_enable_in,
	input  wire logic clear_in,
	input  wire logic request_in,
	// results
	output logic      armed_out,
	output logic      fall_out
);

	logic prev_reg;
	logic armed_reg;
	logic armed_next;
	logic fall_reg;
	logic fall_next;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		armed_next = armed_reg;
		fall_next  = armed_reg & prev_reg & ~request_in & ~clear_in;
		if (clear_in || fall_next)
			armed_next = 1'b0;
		else if (arm_enable_in && request_in)
			armed_next = 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prev_reg  <= 1'b0;
			armed_reg <= 1'b0;
			fall_reg  <= 1'b0;
		end else begin
			prev_reg  <= request_in;
			armed_reg <= armed_next;
			fall_reg  <= fall_next;
		end
	end

	assign armed_out = armed_reg;
	assign fall_out  = fall_reg;

endmodule : pwsc_sleep_watch

// ==== pwsc_props.sv ====
// Purpose: port-level checks of power switch control
// Assumes: strap changes only while reset is high
// Notes:   low run counter stands in for a long repetition
`timescale 1ns/1ps
module pwsc_props #(
	parameter int unsigned DEBOUNCE_CYCLES = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// pins
	input wire logic power_switch_n_in,
	input wire logic switch_type_select_in,
	input wire logic sleep_request_in,
	input wire logic regulator_enable_out,
	input wire logic boost_enable_pin_out,
	input wire logic supervisor_active_out,
	input wire logic charger_active_out,
	// bus
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out
);
	logic [15:0] low_reg;
	logic [15:0] low_next;
	always_comb begin
		low_next = (low_reg == 16'hffff) ? low_reg : low_reg + 16'h1;
		if (power_switch_n_in)
			low_next = 16'h0;
	end
	always_ff @(posedge clk_in) begin
		low_reg <= rst_in ? 16'h0 : low_next;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////////////////
	property p_alive; supervisor_active_out && charger_active_out; endproperty
	a_alive: assert property (p_alive) else $error("supervisor or charger off");
	property p_quiet; !regulator_enable_out |-> !boost_enable_pin_out; endproperty
	a_quiet: assert property (p_quiet) else $error("boost without regulator");
	property p_sl_on;
		(!switch_type_select_in && !power_switch_n_in)[*4] |-> ##[0:3] regulator_enable_out;
	endproperty
	a_sl_on: assert property (p_sl_on) else $error("slider low did not power up");
	property p_sl_off;
		(!switch_type_select_in && power_switch_n_in)[*6] |-> !regulator_enable_out;
	endproperty
	a_sl_off: assert property (p_sl_off) else $error("slider high left power on");
	// a glitch shorter than the debounce time must never power up in push-button mode
	property p_pb_on;
		switch_type_select_in && $rose(regulator_enable_out) |-> low_reg >= DEBOUNCE_CYCLES;
	endproperty
	a_pb_on: assert property (p_pb_on) else $error("power on without long press");
	property p_pb_hold;
		switch_type_select_in && regulator_enable_out && power_switch_n_in && sleep_request_in
		&& !$past(avs_write_in) && !$past(avs_write_in, 2) |=> regulator_enable_out;
	endproperty
	a_pb_hold: assert property (p_pb_hold) else $error("released button dropped power");
	property p_sleep;
		regulator_enable_out && sleep_request_in ##1 sleep_request_in ##1 !sleep_request_in
		|-> ##[1:3] !regulator_enable_out;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep fall kept power");
	property p_wait; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_once; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
	a_once: assert property (p_once) else $error("bus answer held");
	c_pb: cover property (switch_type_select_in && $rose(regulator_enable_out));
	c_sleep: cover property ($fell(sleep_request_in) ##[1:3] $fell(regulator_enable_out));
	c_read: cover property (avs_read_in && !avs_waitrequest_out);
endmodule : pwsc_props

bind pwsc_power_switch_control pwsc_props #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_pwsc_props (
	.clk_in(clk_in), .rst_in(rst_in), .power_switch_n_in(power_switch_n_in),
	.switch_type_select_in(switch_type_select_in), .sleep_request_in(sleep_request_in),
	.regulator_enable_out(regulator_enable_out), .boost_enable_pin_out(boost_enable_pin_out),
	.supervisor_active_out(supervisor_active_out), .charger_active_out(charger_active_out),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_waitrequest_out(avs_waitrequest_out));

// ==== pwsc_host_model.sv ====
// Purpose: user switch and host gpio pins
// Assumes: switch pin is pulled up at rest; sleep and boost requests rest low
// Notes:   every change lands just after a rising edge
`timescale 1ns/1ps
module pwsc_host_model (
	// clock
	input wire logic clk_in,
	// pins
	output logic     switch_n_out,
	output logic     sleep_req_out,
	output logic     boost_req_out
);
	initial begin
		switch_n_out = 1'b1;
		sleep_req_out = 1'b0;
		boost_req_out = 1'b0;
	end
	// v is switch, sleep, boost; held n cycles so slow hosts are modelled too
	task drive(input logic [2:0] v, input int n);
		@(posedge clk_in);
		{switch_n_out, sleep_req_out, boost_req_out} <= v;
		repeat (n) @(posedge clk_in);
	endtask : drive
endmodule : pwsc_host_model

// ==== tb.sv ====
// Purpose: self-checking bench of power switch control
// Assumes: short debounce and power-up counts
// Notes:   strap changes only under reset
`timescale 1ns/1ps
module tb;
	localparam int DEB = 8;
	localparam int PUP = 10;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        switch_type_select = 1'b0;
	logic [3:0]  adr    = 4'h0;
	logic        rd     = 1'b0;
	logic        wr     = 1'b0;
	logic [31:0] wd     = 32'h0;
	logic [31:0] q;
	logic [31:0] rnd    = 32'h24e9;
	logic        sw_n, slp, bst, reg_en, boost_enable_pin, sup, chg, wreq;
	logic [31:0] rdat;
	int          num_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	int          n;
	pwsc_host_model i_pwsc_host_model (.clk_in(clk_in), .switch_n_out(sw_n),
		.sleep_req_out(slp), .boost_req_out(bst));
	pwsc_power_switch_control #(.DEBOUNCE_CYCLES(DEB), .POWERUP_CYCLES(PUP))
	i_pwsc_power_switch_control (.clk_in(clk_in), .rst_in(rst_in), .power_switch_n_in(sw_n),
		.switch_type_select_in(switch_type_select), .sleep_request_in(slp), .boost_request_in(bst),
		.regulator_enable_out(reg_en), .boost_enable_pin_out(boost_enable_pin),
		.supervisor_active_out(sup), .charger_active_out(chg), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wreq));
	////////////////////////////////////////////////////////////////////////////
	initial forever #4 clk_in = ~clk_in;
	function logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function logic [3:0] st_exp(input logic [1:0] s, input logic pb, input logic on);
		return {s, pb, on};
	endfunction : st_exp
	task complete_run;
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one request, held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do @(posedge clk_in); while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task wait_reg(input logic v);
		for (int i = 0; i < 300 && reg_en !== v; i++) @(posedge clk_in);
		chk("regulator", v, reg_en);
	endtask : wait_reg
	task do_reset(input logic s);
		rst_in <= 1'b1;
		switch_type_select <= s;
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
	endtask : do_reset
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(1'b0);
		bus(1'b0, 4'h4, 32'h0);
		chk("status", st_exp(2'd0, 1'b0, 1'b0), {q[7:5], q[1]});
		i_pwsc_host_model.drive(3'b001, 1);
		wait_reg(1'b1);
		repeat (PUP + 4) @(posedge clk_in);
		bus(1'b0, 4'h4, 32'h0);
		chk("status", st_exp(2'd2, 1'b0, 1'b1), {q[7:5], q[1]});
		chk("boost", 1'b1, boost_enable_pin);
		bus(1'b1, 4'h0, 32'h0);
		repeat (3) @(posedge clk_in);
		chk("boost", 1'b0, boost_enable_pin);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h0, q);
		bus(1'b1, 4'h0, 32'h2);
		bus(1'b0, 4'h8, 32'h0);
		chk("unmapped", 32'h0, q);
		i_pwsc_host_model.drive(3'b101, 1);
		wait_reg(1'b0);
		chk("boost", 1'b0, boost_enable_pin);
		chk("alive", 2'b11, {sup, chg});
		do_reset(1'b1);
		i_pwsc_host_model.drive(3'b101, DEB + 4);
		repeat (4) begin
			rnd = lfsr(rnd);
			n = 1 + int'(rnd % (DEB - 2));
			i_pwsc_host_model.drive(3'b001, n);
			i_pwsc_host_model.drive(3'b101, 1);
		end
		chk("regulator", 1'b0, reg_en);
		for (int k = 0; k < 3; k++) begin
			i_pwsc_host_model.drive(3'b101, DEB + 4);
			i_pwsc_host_model.drive(3'b001, DEB + 8);
			chk("regulator", k[0] ? 1'b0 : 1'b1, reg_en);
			i_pwsc_host_model.drive(3'b101, PUP + 8);
			chk("regulator", k[0] ? 1'b0 : 1'b1, reg_en);
		end
		bus(1'b0, 4'h4, 32'h0);
		chk("status", st_exp(2'd2, 1'b1, 1'b1), {q[7:5], q[1]});
		i_pwsc_host_model.drive(3'b111, 3);
		bus(1'b0, 4'h4, 32'h0);
		chk("armed", 32'h1, {31'h0, q[2]});
		i_pwsc_host_model.drive(3'b101, 4);
		chk("regulator", 1'b0, reg_en);
		i_pwsc_host_model.drive(3'b001, DEB + 8);
		i_pwsc_host_model.drive(3'b101, PUP + 8);
		bus(1'b1, 4'h0, 32'h3);
		wait_reg(1'b0);
		complete_run;
	end
endmodule : tb
